// file: logic/trigger_unit_ctrl_irq_regs.sv
// Purpose: Control, load-okay and interrupt-enable registers of the trigger unit, Avalon-MM slave
// Assumes: Reload and generator events are one-cycle pulses on clk; mode levels are asynchronous
// Notes: Every access takes two cycles; waitrequest falls in the second
//
// Summary of operation
// - Unimplemented bits and unmapped words read as zero.
// - Freeze-stop bit halts the time-base counter during freeze; clear lets it count.
// - Enable bit 1 switches trigger generator 1 on or off.
// - Enable bit 0 switches trigger generator 0 on or off.
// - Enable and both interrupt-enable registers are readable and writable any time.
// - With load-okay set, a reload swaps each enabled generator to its alternate list.
// - Reload with load-okay clear keeps the old list and, unless forced, signals overrun.
// - Hardware clears load-okay at the next reload after it was set.
// - Writing one sets load-okay always; writing zero only with both generators off.
// - Load-okay is exported as the global load-okay signal.
// - Reload-overrun enable gates the overrun flag onto the interrupt request.
// - Low enable bits 7..4 gate generator 1 error and done flags.
// - Low enable bits 3..0 gate generator 0 error and done flags.
// - Overrun flag sets on unsanctioned reload, unless commutation forced the reload.
// - Flags read any time; writing one clears, zero leaves them.
// - Stop mode halts counter and triggers, configuration is kept.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module trigger_unit_ctrl_irq_regs
    import trigger_unit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // System mode levels, asynchronous
    input wire logic freezeMode,
    input wire logic stopMode,
    // Events from the reload source and the generators
    input wire logic reloadEvent,
    input wire logic reloadForced,
    input wire trigger_unit_pkg::gen_event_s gen0Event,
    input wire trigger_unit_pkg::gen_event_s gen1Event,
    input wire logic eccErrorEvent,
    // Controls toward the counter and generators
    output logic counterRun,
    output logic [1:0] genRun,
    output logic [1:0] listSel,
    output logic [1:0] listSwap,
    output logic reloadOverrun,
    output logic loadOkayGlobal,
    output logic irq
);
    import trigger_unit_pkg::*;

    // Bus sequencing
    bus_state_e state_ff;
    bus_state_e nxt_state;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;

    // Software-visible control registers
    logic [7:0] moduleEnable_ff;
    logic [7:0] irqEnableHigh_ff;
    logic [7:0] irqEnableLow_ff;
    logic loadOkay_ff;
    logic nxt_loadOkay;

    // Generator-side state
    logic [1:0] listSel_ff;
    logic [1:0] nxt_listSel;
    logic [1:0] listSwap_ff;
    logic reloadOverrun_ff;
    logic counterRun_ff;
    logic [1:0] genRun_ff;
    logic irq_ff;

    // Synchronised modes
    logic [1:0] modeSync;
    logic freezeSync;
    logic stopSync;

    // Flags
    logic [FLAG_HIGH_W-1:0] flagHigh;
    logic [FLAG_LOW_W-1:0] flagLow;
    logic [FLAG_HIGH_W-1:0] flagHighSet;
    logic [FLAG_HIGH_W-1:0] flagHighClr;
    logic [FLAG_LOW_W-1:0] flagLowSet;
    logic [FLAG_LOW_W-1:0] flagLowClr;

    // Decode wires
    logic [5:0] accessIdx;
    logic busRequest;
    logic commitCycle;
    logic lowLaneWrite;
    logic [7:0] wrByte;
    logic wrModuleEnable;
    logic wrModuleControl;
    logic wrIrqEnableHigh;
    logic wrIrqEnableLow;
    logic wrFlagHigh;
    logic wrFlagLow;
    logic freezeStop;
    logic gen0Enable;
    logic gen1Enable;
    logic bothGenOff;
    logic loadOkaySet;
    logic loadOkayClr;
    logic reloadAccepted;
    logic reloadUnsanctioned;
    logic [7:0] readByte;
    logic irqHighTerm;
    logic irqLowTerm;

    // Mode levels come from another domain
    level_sync #(
        .WIDTH(2)
    ) u_mode_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn({stopMode, freezeMode}),
        .syncOut(modeSync)
    );

    assign freezeSync = modeSync[0];
    assign stopSync = modeSync[1];

    // Address and strobe decode; writes land only in the answer cycle
    assign accessIdx = regIndex(address);
    assign busRequest = read | write;
    assign commitCycle = (state_ff == BUS_ANSWER);
    assign lowLaneWrite = write & commitCycle & byteenable[0];
    assign wrByte = writedata[7:0];
    assign wrModuleEnable = lowLaneWrite & (accessIdx == IDX_MODULE_ENABLE);
    assign wrModuleControl = lowLaneWrite & (accessIdx == IDX_MODULE_CONTROL);
    assign wrIrqEnableHigh = lowLaneWrite & (accessIdx == IDX_IRQ_ENABLE_HIGH);
    assign wrIrqEnableLow = lowLaneWrite & (accessIdx == IDX_IRQ_ENABLE_LOW);
    assign wrFlagHigh = lowLaneWrite & (accessIdx == IDX_FLAG_HIGH);
    assign wrFlagLow = lowLaneWrite & (accessIdx == IDX_FLAG_LOW);

    // Field views of the enable register
    assign freezeStop = moduleEnable_ff[FREEZE_STOP_BIT];
    assign gen1Enable = moduleEnable_ff[GEN1_ENABLE_BIT];
    assign gen0Enable = moduleEnable_ff[GEN0_ENABLE_BIT];
    assign bothGenOff = ~gen0Enable & ~gen1Enable;

    // Bus state: one wait cycle, then answer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            BUS_IDLE: begin
                if (busRequest) begin
                    nxt_state = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                nxt_state = BUS_IDLE;
            end
        endcase
    end

    assign waitrequest = busRequest & ~commitCycle;

    // Read mux; masks keep unimplemented bits at zero
    always_comb begin
        readByte = 8'h00;
        unique case (accessIdx)
            IDX_MODULE_ENABLE: begin
                readByte = moduleEnable_ff & MODULE_ENABLE_MASK;
            end
            IDX_MODULE_CONTROL: begin
                readByte = {7'h00, loadOkay_ff} & MODULE_CONTROL_MASK;
            end
            IDX_IRQ_ENABLE_HIGH: begin
                readByte = irqEnableHigh_ff & IRQ_ENABLE_HIGH_MASK;
            end
            IDX_IRQ_ENABLE_LOW: begin
                readByte = irqEnableLow_ff & IRQ_ENABLE_LOW_MASK;
            end
            IDX_FLAG_HIGH: begin
                readByte = {6'h00, flagHigh} & FLAG_HIGH_MASK;
            end
            IDX_FLAG_LOW: begin
                readByte = flagLow;
            end
            default: begin
                readByte = 8'h00;
            end
        endcase
    end

    // Capture read data on the request edge so it stands at the answer edge
    assign nxt_readdata = (read & ~commitCycle) ? {24'h000000, readByte} : readdata_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= BUS_IDLE;
            readdata_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            readdata_ff <= nxt_readdata;
        end
    end

    assign readdata = readdata_ff;

    // Plain read/write control registers; stop mode leaves them untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            moduleEnable_ff <= REG_RESET_VALUE;
            irqEnableHigh_ff <= REG_RESET_VALUE;
            irqEnableLow_ff <= REG_RESET_VALUE;
        end else begin
            if (wrModuleEnable) begin
                moduleEnable_ff <= wrByte & MODULE_ENABLE_MASK;
            end
            if (wrIrqEnableHigh) begin
                irqEnableHigh_ff <= wrByte & IRQ_ENABLE_HIGH_MASK;
            end
            if (wrIrqEnableLow) begin
                irqEnableLow_ff <= wrByte;
            end
        end
    end

    // Load-okay: software one always wins, software zero only with both generators off
    assign loadOkaySet = wrModuleControl & wrByte[LOAD_OKAY_BIT];
    assign loadOkayClr = wrModuleControl & ~wrByte[LOAD_OKAY_BIT] & bothGenOff;
    assign reloadAccepted = reloadEvent & loadOkay_ff;
    assign reloadUnsanctioned = reloadEvent & ~loadOkay_ff;
    // A set racing a reload survives, so software's request is not lost
    assign nxt_loadOkay = loadOkaySet | (loadOkay_ff & ~reloadEvent & ~loadOkayClr);

    // Sanctioned reload swaps the list of each enabled generator
    assign nxt_listSel = reloadAccepted ? (listSel_ff ^ {gen1Enable, gen0Enable}) : listSel_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            loadOkay_ff <= 1'b0;
            listSel_ff <= LIST_RESET_VALUE;
            listSwap_ff <= 2'h0;
            reloadOverrun_ff <= 1'b0;
        end else begin
            loadOkay_ff <= nxt_loadOkay;
            listSel_ff <= nxt_listSel;
            listSwap_ff <= {2{reloadAccepted}} & {gen1Enable, gen0Enable};
            reloadOverrun_ff <= reloadUnsanctioned & ~reloadForced;
        end
    end

    assign loadOkayGlobal = loadOkay_ff;
    assign listSel = listSel_ff;
    assign listSwap = listSwap_ff;
    assign reloadOverrun = reloadOverrun_ff;

    // Flag set and clear strobes
    always_comb begin
        flagHighSet = '0;
        flagHighSet[RELOAD_OVERRUN_FLAG_BIT] = reloadUnsanctioned & ~reloadForced;
        flagHighSet[ECC_ERROR_FLAG_BIT] = eccErrorEvent;
    end

    assign flagHighClr = {FLAG_HIGH_W{wrFlagHigh}} & wrByte[FLAG_HIGH_W-1:0];
    assign flagLowSet = {gen1Event, gen0Event};
    assign flagLowClr = {FLAG_LOW_W{wrFlagLow}} & wrByte;

    flag_w1c #(
        .WIDTH(FLAG_HIGH_W)
    ) u_flag_high (
        .clk(clk),
        .rst(rst),
        .setIn(flagHighSet),
        .clearIn(flagHighClr),
        .flags(flagHigh)
    );

    flag_w1c #(
        .WIDTH(FLAG_LOW_W)
    ) u_flag_low (
        .clk(clk),
        .rst(rst),
        .setIn(flagLowSet),
        .clearIn(flagLowClr),
        .flags(flagLow)
    );

    // Interrupt request: every flag except the ECC error flag against its own enable
    assign irqHighTerm = flagHigh[RELOAD_OVERRUN_FLAG_BIT] & irqEnableHigh_ff[RELOAD_OVERRUN_IRQ_EN_BIT];
    assign irqLowTerm = |(flagLow[GEN1_FIELD_LSB +: 4] & irqEnableLow_ff[GEN1_FIELD_LSB +: 4])
        | |(flagLow[GEN0_FIELD_LSB +: 4] & irqEnableLow_ff[GEN0_FIELD_LSB +: 4]);

    // Registered run controls; freeze gating is chosen by software, stop always halts
    always_ff @(posedge clk) begin
        if (rst) begin
            counterRun_ff <= 1'b0;
            genRun_ff <= 2'h0;
            irq_ff <= 1'b0;
        end else begin
            counterRun_ff <= ~stopSync & ~(freezeSync & freezeStop);
            genRun_ff <= {gen1Enable, gen0Enable} & {2{~stopSync}};
            irq_ff <= irqHighTerm | irqLowTerm;
        end
    end

    assign counterRun = counterRun_ff;
    assign genRun = genRun_ff;
    assign irq = irq_ff;
endmodule

// file: logic/trigger_unit_pkg.sv
// Purpose: Shared constants and types for the trigger unit control and interrupt-enable registers
// Assumes: 8-bit registers, each in the low byte of one aligned 32-bit Avalon word
// Notes: Register indices are word indices; the byte address is four times the index
package trigger_unit_pkg;

    // Register word indices
    localparam logic [5:0] IDX_MODULE_ENABLE = 6'h00;
    localparam logic [5:0] IDX_MODULE_CONTROL = 6'h01;
    localparam logic [5:0] IDX_IRQ_ENABLE_HIGH = 6'h02;
    localparam logic [5:0] IDX_IRQ_ENABLE_LOW = 6'h03;
    localparam logic [5:0] IDX_FLAG_HIGH = 6'h04;
    localparam logic [5:0] IDX_FLAG_LOW = 6'h05;

    // Field positions
    localparam int FREEZE_STOP_BIT = 6;
    localparam int GEN1_ENABLE_BIT = 1;
    localparam int GEN0_ENABLE_BIT = 0;
    localparam int LOAD_OKAY_BIT = 0;
    localparam int RELOAD_OVERRUN_IRQ_EN_BIT = 0;
    localparam int RELOAD_OVERRUN_FLAG_BIT = 0;
    localparam int ECC_ERROR_FLAG_BIT = 1;
    localparam int GEN1_FIELD_LSB = 4;
    localparam int GEN0_FIELD_LSB = 0;

    // Implemented bits per register; all others read zero
    localparam logic [7:0] MODULE_ENABLE_MASK = 8'h43;
    localparam logic [7:0] MODULE_CONTROL_MASK = 8'h01;
    localparam logic [7:0] IRQ_ENABLE_HIGH_MASK = 8'h01;
    localparam logic [7:0] IRQ_ENABLE_LOW_MASK = 8'hff;
    localparam logic [7:0] FLAG_HIGH_MASK = 8'h03;

    // Values after reset
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic [1:0] LIST_RESET_VALUE = 2'h0;

    // Widths
    localparam int FLAG_HIGH_W = 2;
    localparam int FLAG_LOW_W = 8;

    // Per-generator events, bit order equals the flag and enable field order
    typedef struct packed {
        logic accessErr;
        logic reloadErr;
        logic timingErr;
        logic done;
    } gen_event_s;

    // Bus answer sequencing
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_e;

    // Word index from an Avalon byte address
    function automatic logic [5:0] regIndex(input logic [7:0] byteAddr);
        regIndex = byteAddr[7:2];
    endfunction

endpackage

// file: logic/level_sync.sv
// Purpose: Two-flop synchroniser for slow system mode levels
// Assumes: Inputs are levels, not pulses
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    initial begin
        if (WIDTH < 1) begin
            $error("level_sync needs at least one bit");
        end
    end

    // Metastability settles in stage 1 before anyone reads it
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule

// file: logic/flag_w1c.sv
// Purpose: Sticky event flags, cleared by writing one
// Assumes: Set and clear strobes are single-cycle on clk
// Notes: A set in the clearing cycle survives
`timescale 1ns/1ps
module flag_w1c #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] setIn,
    input wire logic [WIDTH-1:0] clearIn,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_ff;
    logic [WIDTH-1:0] nxt_flags;

    initial begin
        if (WIDTH < 1) begin
            $error("flag_w1c needs at least one bit");
        end
    end

    // Set wins over clear so no event is lost
    assign nxt_flags = (flags_ff & ~clearIn) | setIn;

    always_ff @(posedge clk) begin
        if (rst) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;
endmodule

// file: dv/trigger_unit_monitor.sv
// Purpose: Port checks for the trigger unit register block
// Assumes: One wait cycle per access, one-cycle event pulses
// Notes: Bound to the block; sees its ports only
`timescale 1ns/1ps
module trigger_unit_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic reloadEvent,
    input wire logic reloadForced,
    input wire logic stopMode,
    input wire logic counterRun,
    input wire logic [1:0] genRun,
    input wire logic [1:0] listSel,
    input wire logic [1:0] listSwap,
    input wire logic reloadOverrun,
    input wire logic loadOkayGlobal,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bus answers after one wait cycle, never stalls longer
    AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    AST_IDLE: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest while idle");
    // Reload consumes load-okay unless software sets it again
    AST_LDOK_CLR: assert property (reloadEvent && loadOkayGlobal && !(write && !waitrequest) |=> !loadOkayGlobal)
        else $error("load-okay kept after reload");
    AST_OVERRUN: assert property (reloadEvent && !reloadForced && !loadOkayGlobal |=> reloadOverrun)
        else $error("overrun missing");
    AST_FORCED: assert property (reloadEvent && reloadForced |=> !reloadOverrun)
        else $error("overrun on forced reload");
    AST_SWAP: assert property (reloadEvent && loadOkayGlobal && genRun[0] |=> listSwap[0] && listSel[0] != $past(listSel[0]))
        else $error("list not swapped");
    AST_KEEP: assert property (reloadEvent && !loadOkayGlobal |=> $stable(listSel) && listSwap == 2'h0)
        else $error("list changed without load-okay");
    // Four samples cover two sync flops plus the output register
    AST_STOP: assert property (stopMode [*4] |-> !counterRun && genRun == 2'h0)
        else $error("running in stop");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(write, 2))
        else $error("irq dropped without a write");
endmodule
bind trigger_unit_ctrl_irq_regs trigger_unit_monitor mon (.clk(clk), .rst(rst), .read(read), .write(write),
    .waitrequest(waitrequest), .reloadEvent(reloadEvent), .reloadForced(reloadForced), .stopMode(stopMode),
    .counterRun(counterRun), .genRun(genRun), .listSel(listSel), .listSwap(listSwap),
    .reloadOverrun(reloadOverrun), .loadOkayGlobal(loadOkayGlobal), .irq(irq));

// file: dv/trigger_unit_ctrl_irq_regs_tb.sv
// Purpose: Self-checking bench for the trigger unit register block
// Assumes: Avalon answer after one wait cycle
// Notes: Reads queue their expectation; a monitor compares
`timescale 1ns/1ps
module trigger_unit_ctrl_irq_regs_tb;
    import trigger_unit_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic freezeMode = 1'b0;
    logic stopMode = 1'b0;
    logic reloadEvent = 1'b0;
    logic reloadForced = 1'b0;
    gen_event_s gen0Event = 4'h0;
    gen_event_s gen1Event = 4'h0;
    logic eccErrorEvent = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, counterRun, reloadOverrun, loadOkayGlobal, irq;
    logic [1:0] genRun, listSel, listSwap;
    logic [31:0] expQ[$];
    int fails = 0;
    int samplesChecked = 0;
    logic [7:0] v, m;

    trigger_unit_ctrl_irq_regs dut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .freezeMode(freezeMode), .stopMode(stopMode), .reloadEvent(reloadEvent), .reloadForced(reloadForced),
        .gen0Event(gen0Event), .gen1Event(gen1Event), .eccErrorEvent(eccErrorEvent), .counterRun(counterRun),
        .genRun(genRun), .listSel(listSel), .listSwap(listSwap), .reloadOverrun(reloadOverrun),
        .loadOkayGlobal(loadOkayGlobal), .irq(irq));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samplesChecked++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Hold the request until waitrequest is seen low, then idle one edge
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        address <= {idx, 2'b00};
        writedata <= {24'($urandom), d};
        read <= !w;
        write <= w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        expQ.push_back({24'h0, e});
        bus(1'b0, idx, 8'h00);
    endtask

    task automatic reload(input logic f);
        reloadForced <= f;
        reloadEvent <= 1'b1;
        @(posedge clk);
        reloadEvent <= 1'b0;
        reloadForced <= 1'b0;
        tick(3);
    endtask

    // Read data taken at the edge where the answer stands
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (expQ.size() == 0) begin
                chk("readQueue", 32'h1, 32'h0);
            end else begin
                chk("readdata", readdata, expQ.pop_front());
            end
        end
    end

    // Generous bound; the sequence needs well under 2000 cycles
    initial begin
        tick(20000);
        fails++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h64b7));
        tick(8);
        rst <= 1'b0;
        wr(6'h07, 8'hff);
        for (int i = 0; i < 8; i++) rd(6'(i), 8'h00);
        // Random values through every plain register
        for (int k = 0; k < 3; k++) begin
            v = 8'($urandom);
            wr(6'(k * 2 - (k == 2)), v);
            rd(6'(k * 2 - (k == 2)), v & (k == 0 ? MODULE_ENABLE_MASK : k == 1 ? 8'h01 : 8'hff));
        end
        wr(IDX_MODULE_ENABLE, 8'h01);
        tick(2);
        chk("genRun0", 32'(genRun), 32'h1);
        wr(IDX_MODULE_ENABLE, 8'h02);
        tick(2);
        chk("genRun1", 32'(genRun), 32'h2);
        // Clearing load-okay refused while a generator runs
        wr(IDX_MODULE_CONTROL, 8'h01);
        wr(IDX_MODULE_CONTROL, 8'h00);
        rd(IDX_MODULE_CONTROL, 8'h01);
        chk("ldokOut", 32'(loadOkayGlobal), 32'h1);
        wr(IDX_MODULE_ENABLE, 8'h00);
        wr(IDX_MODULE_CONTROL, 8'h00);
        rd(IDX_MODULE_CONTROL, 8'h00);
        wr(IDX_MODULE_ENABLE, 8'h01);
        wr(IDX_MODULE_CONTROL, 8'h01);
        wr(IDX_IRQ_ENABLE_HIGH, 8'h01);
        reload(1'b0);
        chk("listSwapped", 32'(listSel), 32'h1);
        chk("ldokCleared", 32'(loadOkayGlobal), 32'h0);
        chk("irqQuiet", 32'(irq), 32'h0);
        // Reload without load-okay: overrun, list kept
        reload(1'b0);
        chk("listKept", 32'(listSel), 32'h1);
        chk("irqOverrun", 32'(irq), 32'h1);
        wr(IDX_FLAG_HIGH, 8'h00);
        rd(IDX_FLAG_HIGH, 8'h01);
        wr(IDX_FLAG_HIGH, 8'h01);
        tick(2);
        chk("irqCleared", 32'(irq), 32'h0);
        reload(1'b1);
        rd(IDX_FLAG_HIGH, 8'h00);
        // Memory error flag has no enable, so it must never reach irq
        eccErrorEvent <= 1'b1;
        @(posedge clk);
        eccErrorEvent <= 1'b0;
        tick(3);
        rd(IDX_FLAG_HIGH, 8'h02);
        chk("irqNoEccPath", 32'(irq), 32'h0);
        wr(IDX_FLAG_HIGH, 8'h02);
        rd(IDX_FLAG_HIGH, 8'h00);
        wr(IDX_IRQ_ENABLE_HIGH, 8'h00);
        reload(1'b0);
        chk("irqMaskedOvr", 32'(irq), 32'h0);
        wr(IDX_FLAG_HIGH, 8'h01);
        // Each generator flag against its own enable bit
        for (int j = 0; j < 8; j++) begin
            m = 8'h01 << j;
            wr(IDX_IRQ_ENABLE_LOW, ~m);
            {gen1Event, gen0Event} <= m;
            @(posedge clk);
            {gen1Event, gen0Event} <= 8'h00;
            tick(3);
            chk("irqMasked", 32'(irq), 32'h0);
            rd(IDX_FLAG_LOW, m);
            wr(IDX_IRQ_ENABLE_LOW, m);
            tick(2);
            chk("irqEnabled", 32'(irq), 32'h1);
            wr(IDX_FLAG_LOW, m);
            tick(2);
            chk("irqFlagClr", 32'(irq), 32'h0);
        end
        // Write with the low byte lane off must leave the register alone
        byteenable <= 4'he;
        wr(IDX_IRQ_ENABLE_LOW, 8'h00);
        byteenable <= 4'hf;
        rd(IDX_IRQ_ENABLE_LOW, 8'h80);
        wr(IDX_MODULE_ENABLE, 8'h43);
        freezeMode <= 1'b1;
        tick(5);
        chk("frozen", 32'(counterRun), 32'h0);
        wr(IDX_MODULE_ENABLE, 8'h03);
        tick(2);
        chk("freezeRun", 32'(counterRun), 32'h1);
        freezeMode <= 1'b0;
        stopMode <= 1'b1;
        tick(5);
        chk("stopped", {counterRun, genRun}, 32'h0);
        rd(IDX_MODULE_ENABLE, 8'h03);
        stopMode <= 1'b0;
        tick(5);
        chk("resumed", {counterRun, genRun}, 32'h7);
        // Reset in mid-run clears everything
        rst <= 1'b1;
        tick(8);
        rst <= 1'b0;
        tick(2);
        chk("afterRst", {genRun, loadOkayGlobal, irq, listSel}, 32'h0);
        rd(IDX_IRQ_ENABLE_LOW, 8'h00);
        tick(2);
        end_of_test();
    end
endmodule
